// ===== core/dnlc_band_if.sv
`timescale 1ns/1ps
interface dnlc_band_if;
   dnlc_pkg::dnlc_lux_t level;
   dnlc_pkg::dnlc_lux_t upper;
   dnlc_pkg::dnlc_lux_t lower;
   logic                update;
   logic                above;
   modport owner (output level, upper, lower, update, input above);
   modport cmp (input level, upper, lower, update, output above);
endinterface

// ===== core/dnlc_hyst.sv
`timescale 1ns/1ps
module dnlc_hyst #(
   parameter logic RST_ABOVE = 1'b0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   dnlc_band_if.cmp band
);
   logic above_reg;

   // ------------------------------------------------------------
   // two-threshold comparator
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         above_reg <= RST_ABOVE;
      end else if (ce && band.update) begin
         if (band.level > band.upper) begin
            above_reg <= 1'b1;
         end else if (band.level < band.lower) begin
            above_reg <= 1'b0;
         end
      end
   end

   assign band.above = above_reg;

   band_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && band.update && band.level <= band.upper
         && band.level >= band.lower |=> $stable(above_reg))
      else $error("band state changed inside hysteresis");
endmodule // dnlc_hyst

// ===== core/dnlc_params.svh
`ifndef DNLC_PARAMS_SVH
`define DNLC_PARAMS_SVH

// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define DNLC_REG_CTRL    12'h000
`define DNLC_REG_STAT    12'h004
`define DNLC_REG_LUX     12'h008
`define DNLC_REG_DUTY    12'h00c
`define DNLC_RUN_RST     1'b1

// ------------------------------------------------------------
// sensor registers and codes
// ------------------------------------------------------------
`define DNLC_SA_CFG      8'h01
`define DNLC_SA_LO       8'h02
`define DNLC_SA_HI       8'h03
`define DNLC_CFG_OFF     16'hc800
`define DNLC_CFG_ALERT   16'hce10
`define DNLC_CFG_AUTO    16'hce00
`define DNLC_RN_AUTO     4'hc
`define DNLC_LIM_MAX     16'hbfff
`define DNLC_LIM_MIN     16'h0000
`define DNLC_LIM_DARK_HI 16'h2fa0
`define DNLC_LIM_DARK_LO 16'h2e6a
`define DNLC_EXP_MAX     4'hb

// ------------------------------------------------------------
// thresholds in hundredths of a lux, and the duty shift
// ------------------------------------------------------------
`define DNLC_DARK_HI     24'h005208
`define DNLC_DARK_LO     24'h004e20
`define DNLC_OFF_HI      24'h003e80
`define DNLC_OFF_LO      24'h003a98
`define DNLC_FULL_HI     24'h001388
`define DNLC_FULL_LO     24'h000fa0
`define DNLC_DUTY_SHIFT  6
`endif

// ===== core/dnlc_pkg.sv
package dnlc_pkg;
   typedef enum logic [7:0] {
      S_INIT = 8'h01,
      S_SEL  = 8'h02,
      S_LO   = 8'h04,
      S_HI   = 8'h08,
      S_CFG  = 8'h10,
      S_WAIT = 8'h20,
      S_RUN  = 8'h40,
      S_IDLE = 8'h80
   } dnlc_state_t;
   typedef logic [23:0] dnlc_lux_t;
endpackage

// ===== core/dnlc_pwm.sv
`timescale 1ns/1ps
module dnlc_pwm #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic         off,
   input  wire logic         full,
   input  wire logic [W-1:0] duty,
   output logic              pwm
);
   logic [W-1:0] cnt_reg;

   // ------------------------------------------------------------
   // free counter and pin
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm <= 1'b0;
      end else if (ce) begin
         if (off) begin
            pwm <= 1'b0;
         end else if (full) begin
            pwm <= 1'b1;
         end else begin
            pwm <= (cnt_reg < duty);
         end
      end
   end
endmodule // dnlc_pwm

// ===== core/dnlc_top.sv
`timescale 1ns/1ps
`include "dnlc_params.svh"
module dnlc_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mode_select_button,
   input  wire logic        alert_n,
   output logic             sens_wr_valid,
   input  wire logic        sens_wr_ready,
   output logic      [7:0]  sens_wr_addr,
   output logic      [15:0] sens_wr_data,
   input  wire logic        sens_rd_valid,
   input  wire logic [15:0] sens_rd_data,
   output logic             ir_cut_filter,
   output logic             motor_en,
   output logic      [1:0]  led_drv_en,
   output logic             led_pwm
);
   dnlc_pkg::dnlc_state_t st_reg;
   dnlc_pkg::dnlc_state_t st_next;
   logic [7:0]            wa_reg;
   logic [7:0]            wa_next;
   logic [15:0]           wd_reg;
   logic [15:0]           wd_next;
   logic                  run_reg;
   logic                  mode_auto_reg;
   logic                  day_reg;
   logic                  armed_reg;
   logic                  active_reg;
   logic                  hi_done_reg;
   logic                  alert_d_reg;
   logic                  upd_reg;
   dnlc_pkg::dnlc_lux_t   lux_reg;
   logic [7:0]            duty_reg;
   logic [31:0]           prdata_reg;
   logic                  wr_ok;
   logic                  alert_fall;
   logic                  led_off;
   logic                  led_full;
   logic                  apb_acc;
   logic                  mapped;
   dnlc_pkg::dnlc_lux_t   diff;

   dnlc_band_if band_dark ();
   dnlc_band_if band_off ();
   dnlc_band_if band_full ();

   function automatic dnlc_pkg::dnlc_lux_t to_clx(logic [15:0] r);
      logic [3:0] e;
      e = (r[15:12] > `DNLC_EXP_MAX) ? `DNLC_EXP_MAX : r[15:12];
      return {12'h000, r[11:0]} << e;
   endfunction

   // ------------------------------------------------------------
   // sensor write sequencer
   // ------------------------------------------------------------
   assign wr_ok = sens_wr_valid & sens_wr_ready;
   assign alert_fall = alert_d_reg & ~alert_n;
   assign sens_wr_valid = (st_reg == dnlc_pkg::S_INIT)
      | (st_reg == dnlc_pkg::S_LO) | (st_reg == dnlc_pkg::S_HI)
      | (st_reg == dnlc_pkg::S_CFG);
   assign sens_wr_addr = wa_reg;
   assign sens_wr_data = wd_reg;

   always_comb begin
      st_next = st_reg;
      wa_next = wa_reg;
      wd_next = wd_reg;
      case (st_reg)
         dnlc_pkg::S_INIT: begin
            if (wr_ok) begin
               st_next = run_reg ? dnlc_pkg::S_SEL : dnlc_pkg::S_IDLE;
            end
         end
         dnlc_pkg::S_SEL: begin
            if (mode_select_button) begin
               st_next = dnlc_pkg::S_CFG;
               wa_next = `DNLC_SA_CFG;
               wd_next = `DNLC_CFG_AUTO;
            end else begin
               st_next = dnlc_pkg::S_LO;
               wa_next = `DNLC_SA_LO;
               wd_next = `DNLC_LIM_MIN;
            end
         end
         dnlc_pkg::S_LO: begin
            if (wr_ok) begin
               st_next = dnlc_pkg::S_HI;
               wa_next = `DNLC_SA_HI;
               wd_next = day_reg ? `DNLC_LIM_MAX : `DNLC_LIM_DARK_HI;
            end
         end
         dnlc_pkg::S_HI: begin
            if (wr_ok && armed_reg) begin
               st_next = dnlc_pkg::S_WAIT;
            end else if (wr_ok) begin
               st_next = dnlc_pkg::S_CFG;
               wa_next = `DNLC_SA_CFG;
               wd_next = `DNLC_CFG_ALERT;
            end
         end
         dnlc_pkg::S_CFG: begin
            if (wr_ok) begin
               st_next = mode_auto_reg ? dnlc_pkg::S_RUN
                                       : dnlc_pkg::S_WAIT;
            end
         end
         dnlc_pkg::S_WAIT: begin
            if (alert_fall) begin
               st_next = dnlc_pkg::S_LO;
               wa_next = `DNLC_SA_LO;
               wd_next = day_reg ? `DNLC_LIM_MIN : `DNLC_LIM_DARK_LO;
            end
         end
         dnlc_pkg::S_RUN: begin
            st_next = dnlc_pkg::S_RUN;
         end
         dnlc_pkg::S_IDLE: begin
            if (run_reg) begin
               st_next = dnlc_pkg::S_SEL;
            end
         end
         default: begin
            st_next = dnlc_pkg::S_INIT;
         end
      endcase
      if (!run_reg && (st_reg == dnlc_pkg::S_WAIT
                       || st_reg == dnlc_pkg::S_RUN)) begin
         st_next = dnlc_pkg::S_INIT;
         wa_next = `DNLC_SA_CFG;
         wd_next = `DNLC_CFG_OFF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= dnlc_pkg::S_INIT;
         wa_reg <= `DNLC_SA_CFG;
         wd_reg <= `DNLC_CFG_OFF;
      end else if (ce) begin
         st_reg <= st_next;
         wa_reg <= wa_next;
         wd_reg <= wd_next;
      end
   end

   // ------------------------------------------------------------
   // mode and progress flags
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_auto_reg <= 1'b0;
      end else if (ce && st_reg == dnlc_pkg::S_SEL) begin
         mode_auto_reg <= mode_select_button;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg   <= 1'b0;
         active_reg  <= 1'b0;
         hi_done_reg <= 1'b0;
      end else if (ce) begin
         if (st_reg == dnlc_pkg::S_INIT
             || st_next == dnlc_pkg::S_INIT) begin
            armed_reg   <= 1'b0;
            active_reg  <= 1'b0;
            hi_done_reg <= 1'b0;
         end else begin
            if (wr_ok && st_reg == dnlc_pkg::S_HI) begin
               hi_done_reg <= 1'b1;
            end
            if (wr_ok && st_reg == dnlc_pkg::S_CFG) begin
               armed_reg  <= 1'b1;
               active_reg <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_d_reg <= 1'b1;
      end else if (ce) begin
         alert_d_reg <= alert_n;
      end
   end

   // ------------------------------------------------------------
   // day or night decision
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         day_reg <= 1'b0;
      end else if (ce) begin
         if (st_reg == dnlc_pkg::S_INIT) begin
            day_reg <= 1'b0;
         end else if (st_reg == dnlc_pkg::S_WAIT && alert_fall) begin
            day_reg <= ~day_reg;
         end else if (st_reg == dnlc_pkg::S_RUN) begin
            day_reg <= band_dark.above;
         end
      end
   end

   // ------------------------------------------------------------
   // measurement and dimming
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lux_reg <= '0;
         upd_reg <= 1'b0;
      end else if (ce) begin
         upd_reg <= 1'b0;
         if (sens_rd_valid && st_reg == dnlc_pkg::S_RUN) begin
            lux_reg <= to_clx(sens_rd_data);
            upd_reg <= 1'b1;
         end
      end
   end

   assign diff = `DNLC_OFF_HI - lux_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_reg <= '0;
      end else if (ce && upd_reg) begin
         if (lux_reg >= `DNLC_OFF_HI) begin
            duty_reg <= '0;
         end else if ((diff >> `DNLC_DUTY_SHIFT) > 24'h0000ff) begin
            duty_reg <= 8'hff;
         end else begin
            duty_reg <= diff[`DNLC_DUTY_SHIFT +: 8];
         end
      end
   end

   assign band_dark.level  = lux_reg;
   assign band_dark.upper  = `DNLC_DARK_HI;
   assign band_dark.lower  = `DNLC_DARK_LO;
   assign band_dark.update = upd_reg;
   assign band_off.level   = lux_reg;
   assign band_off.upper   = `DNLC_OFF_HI;
   assign band_off.lower   = `DNLC_OFF_LO;
   assign band_off.update  = upd_reg;
   assign band_full.level  = lux_reg;
   assign band_full.upper  = `DNLC_FULL_HI;
   assign band_full.lower  = `DNLC_FULL_LO;
   assign band_full.update = upd_reg;

   dnlc_hyst #(.RST_ABOVE(1'b0)) u_dark (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .band    (band_dark)
   );
   dnlc_hyst #(.RST_ABOVE(1'b1)) u_off (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .band    (band_off)
   );
   dnlc_hyst #(.RST_ABOVE(1'b1)) u_full (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .band    (band_full)
   );

   // ------------------------------------------------------------
   // actuators
   // ------------------------------------------------------------
   assign led_off = ~active_reg
      | (mode_auto_reg ? band_off.above : day_reg);
   assign led_full = mode_auto_reg ? ~band_full.above : 1'b1;
   assign ir_cut_filter = day_reg;
   assign motor_en = active_reg;
   assign led_drv_en = {2{~led_off}};

   dnlc_pwm #(.W(8)) u_pwm (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .off     (led_off),
      .full    (led_full),
      .duty    (duty_reg),
      .pwm     (led_pwm)
   );

   // ------------------------------------------------------------
   // apb slave
   // ------------------------------------------------------------
   assign apb_acc = psel & penable;
   assign mapped = (paddr == `DNLC_REG_CTRL) | (paddr == `DNLC_REG_STAT)
      | (paddr == `DNLC_REG_LUX) | (paddr == `DNLC_REG_DUTY);
   assign pready = ce;
   assign pslverr = apb_acc & ~mapped;
   assign prdata = prdata_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_reg <= `DNLC_RUN_RST;
      end else if (ce && apb_acc && pwrite
                   && paddr == `DNLC_REG_CTRL) begin
         run_reg <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= '0;
      end else if (ce && psel && !penable && !pwrite) begin
         case (paddr)
            `DNLC_REG_CTRL: prdata_reg <= {31'h0, run_reg};
            `DNLC_REG_STAT: prdata_reg <= {16'h0, st_reg, 3'h0,
               active_reg, led_full, led_off, day_reg, mode_auto_reg};
            `DNLC_REG_LUX: prdata_reg <= {8'h00, lux_reg};
            `DNLC_REG_DUTY: prdata_reg <= {24'h0, duty_reg};
            default: prdata_reg <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   init_low_power_a: assert property (
      st_reg == dnlc_pkg::S_INIT |-> !motor_en && led_drv_en == 2'b00
         && sens_wr_data == `DNLC_CFG_OFF)
      else $error("not in low power during init");
   mode_pick_a: assert property (
      ce && st_reg == dnlc_pkg::S_SEL |=>
         mode_auto_reg == $past(mode_select_button))
      else $error("mode not taken from button");
   limits_first_a: assert property (
      st_reg == dnlc_pkg::S_CFG && !mode_auto_reg |-> hi_done_reg)
      else $error("alert config before limits");
   alert_only_a: assert property (
      ce && st_reg == dnlc_pkg::S_WAIT && run_reg && !alert_fall
         |=> st_reg == dnlc_pkg::S_WAIT)
      else $error("left alert wait without alert");
   start_limits_a: assert property (
      st_reg == dnlc_pkg::S_HI && !day_reg
         |-> sens_wr_data == `DNLC_LIM_DARK_HI)
      else $error("wrong night high limit");
   day_alert_a: assert property (
      ce && st_reg == dnlc_pkg::S_WAIT && run_reg && alert_fall && !day_reg
         |=> day_reg && sens_wr_data == `DNLC_LIM_DARK_LO
         ##1 led_drv_en == 2'b00)
      else $error("bright alert mishandled");
   night_alert_a: assert property (
      ce && st_reg == dnlc_pkg::S_WAIT && run_reg && alert_fall && day_reg
         |=> !ir_cut_filter ##1 led_drv_en == 2'b11)
      else $error("dark alert mishandled");
   night_reload_a: assert property (
      $fell(day_reg) && !mode_auto_reg
         && !$past(st_reg == dnlc_pkg::S_INIT)
         |-> st_reg == dnlc_pkg::S_LO && sens_wr_data == `DNLC_LIM_MIN)
      else $error("night reload wrong");
   day_high_a: assert property (
      st_reg == dnlc_pkg::S_HI && day_reg |-> sens_wr_data == `DNLC_LIM_MAX)
      else $error("day high limit wrong");
   auto_range_a: assert property (
      st_reg == dnlc_pkg::S_CFG && mode_auto_reg
         |-> sens_wr_data[15:12] == `DNLC_RN_AUTO)
      else $error("auto range not selected");
   full_on_a: assert property (
      ce && st_reg == dnlc_pkg::S_RUN && !led_off && led_full
         |=> led_pwm)
      else $error("led pin not held high");

   day_seen_c: cover property (st_reg == dnlc_pkg::S_LO && $rose(day_reg));
   night_seen_c: cover property (st_reg == dnlc_pkg::S_LO
      && $fell(day_reg));
   dim_band_c: cover property (st_reg == dnlc_pkg::S_RUN && !led_off
      && !led_full && duty_reg != 8'h00);
   full_band_c: cover property (st_reg == dnlc_pkg::S_RUN && led_full
      && !led_off);
endmodule // dnlc_top

// ===== verif/dnlc_sensor_model.sv
`timescale 1ns/1ps
// ----
// sensor access agent and result source
// ----
module dnlc_sensor_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        slow,
   input  wire logic        wr_valid,
   input  wire logic [7:0]  wr_addr,
   input  wire logic [15:0] wr_data,
   output logic             wr_ready,
   output logic             alert_n,
   output logic             rd_valid,
   output logic      [15:0] rd_data
);
   logic [23:0] wlog [0:15];
   int          wcnt;
   logic        tick;
   assign wr_ready = slow ? tick : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wcnt <= 0;
         tick <= 1'b0;
      end else begin
         tick <= ~tick;
         if (wr_valid && wr_ready) begin
            wlog[wcnt[3:0]] <= {wr_addr, wr_data};
            wcnt <= wcnt + 1;
         end
      end
   end
   initial begin
      alert_n = 1'b1;
      rd_valid = 1'b0;
      rd_data = 16'h0;
   end
   // range chosen per result, reported at any time
   task automatic result(input logic [15:0] code);
      @(posedge pclk);
      rd_valid <= 1'b1;
      rd_data <= code;
      @(posedge pclk);
      rd_valid <= 1'b0;
      rd_data <= ~code;
   endtask
   task automatic alert(input logic lvl);
      @(posedge pclk);
      alert_n <= lvl;
   endtask
endmodule // dnlc_sensor_model

// ===== verif/tb.sv
`timescale 1ns/1ps
module tb;
   logic        pclk = 1'b0, presetn = 1'b0, btn = 1'b0, slow = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, wv, wr, fil, men, pwm, an, rv;
   logic [7:0]  wa;
   logic [15:0] wd, rdd;
   logic [1:0]  len;
   int          failures = 0, samples_checked = 0;
   logic [23:0] alog [0:9] = '{24'h01c800, 24'h020000, 24'h032fa0,
      24'h01ce10, 24'h022e6a, 24'h03bfff, 24'h020000, 24'h032fa0,
      24'h01c800, 24'h01ce00};
   // code, duty, {full, off, day}
   logic [31:0] rows [0:10] = '{32'h3ea6_0003, 32'h3a00_0003,
      32'h3947_0002, 32'h2f23_0702, 32'h29c4_5d00, 32'h1fa0_7d00,
      32'h18ca_b300, 32'h0bb8_cb04, 32'h18ca_b304, 32'h1bb8_9c00,
      32'h2f23_0700};
   always #5 pclk = ~pclk;
   dnlc_top i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_select_button(btn), .alert_n(an),
      .sens_wr_valid(wv), .sens_wr_ready(wr), .sens_wr_addr(wa),
      .sens_wr_data(wd), .sens_rd_valid(rv), .sens_rd_data(rdd),
      .ir_cut_filter(fil), .motor_en(men), .led_drv_en(len),
      .led_pwm(pwm));
   dnlc_sensor_model i_sens (.pclk(pclk), .presetn(presetn),
      .slow(slow), .wr_valid(wv), .wr_addr(wa), .wr_data(wd),
      .wr_ready(wr), .alert_n(an), .rd_valid(rv), .rd_data(rdd));
   // ----
   // checks and bus cycles
   // ----
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("failures %0d checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         results();
      end
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_st(input logic [7:0] st);
      int n;
      n = 0;
      do begin
         apb(1'b0, 12'h004, 32'h0);
         n++;
      end while (rd[15:8] !== st && n < 100);
      if (n >= 100) begin
         failures++;
         results();
      end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      chk({wv, wa, wd}, 25'h101c800);
      chk({fil, men, len, pwm}, 5'h0);
      presetn <= 1'b1;
      wait_st(8'h20);
      chk(rd[0], 1'b0);
      for (int i = 0; i < 4; i++) chk(i_sens.wlog[i], alog[i]);
      chk({fil, men, len}, 4'h7);
      i_sens.alert(1'b0);
      repeat (20) @(posedge pclk);
      chk(i_sens.wcnt, 32'h6);
      for (int i = 4; i < 6; i++) chk(i_sens.wlog[i], alog[i]);
      chk({fil, len, pwm}, 4'h8);
      i_sens.alert(1'b1);
      repeat (5) @(posedge pclk);
      i_sens.alert(1'b0);
      repeat (20) @(posedge pclk);
      for (int i = 6; i < 8; i++) chk(i_sens.wlog[i], alog[i]);
      chk({fil, len}, 3'h3);
      apb(1'b0, 12'h010, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h1);
      btn <= 1'b1;
      slow <= 1'b1;
      apb(1'b1, 12'h000, 32'h0);
      wait_st(8'h80);
      chk({men, len}, 3'h0);
      apb(1'b1, 12'h000, 32'h1);
      wait_st(8'h40);
      chk(rd[0], 1'b1);
      chk(i_sens.wlog[8], alog[8]);
      chk(i_sens.wlog[9], alog[9]);
      chk(i_sens.wlog[9][15:12], 4'hc);
      for (int i = 0; i < 11; i++) begin
         i_sens.result(rows[i][31:16]);
         repeat (6 + 30 * (i % 3)) @(posedge pclk);
         apb(1'b0, 12'h004, 32'h0);
         chk(rd[3:1], rows[i][2:0]);
         chk(fil, rows[i][0]);
         chk(len, {2{~rows[i][1]}});
         if (rows[i][2]) chk(pwm, 1'b1);
         if (rows[i][1]) chk(pwm, 1'b0);
         apb(1'b0, 12'h00c, 32'h0);
         chk(rd[7:0], rows[i][15:8]);
      end
      results();
   end
endmodule // tb
